// ---- src/tmr2_ctrl.sv ----
// Purpose: timer 2 run, gate, single-shot capture, reload and pwm routing
// Assumes: avalon-mm slave with waitrequest, one clock, async low reset
// Notes: count increments once per clock, or per pin rise in counter mode
`timescale 1ns/1ns
module tmr2_ctrl #(
  parameter int COUNT_W = tmr2_pkg::COUNT_W
) (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic [tmr2_pkg::ADDR_W-1:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [tmr2_pkg::DATA_W-1:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [tmr2_pkg::DATA_W-1:0] READDATA,
  output logic WAITREQUEST,
  output logic IRQ,
  input wire logic PIN_A_I,
  output logic PIN_A_O,
  output logic PIN_A_OE,
  output logic PIN_B_O,
  output logic PIN_B_OE
);
  import tmr2_pkg::*;

  // the byte-split logic assumes a 16-bit counter
  if (COUNT_W != 2 * HALF_W) begin : g_bad_width
    $error("tmr2_ctrl supports only a 16-bit counter");
  end

  logic [CTRL_A_W-1:0] ctrl_a;
  logic [CTRL_B_W-1:0] ctrl_b;
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] capture;
  logic [COUNT_W-1:0] reload;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] irq_en;
  tmr2_ss_t ss;
  logic out_en0_q;
  logic out_en1_q;
  logic pwm_h;
  logic pwm_l;
  logic pin_lvl;
  logic pin_rise;
  logic pin_fall;

  tmr2_pin_sync u_sync (
    .clk(CLOCK),
    .arst_n(ARST_N),
    .pin(PIN_A_I),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // bus decode; access completes at the edge waitrequest is seen low
  wire req = READ | WRITE;
  wire acc = WRITE & ~WAITREQUEST;
  wire [DATA_W-1:0] wmask = {16'h0000, {8{BYTEENABLE[1]}},
    {8{BYTEENABLE[0]}}};
  wire wr_a = acc & (ADDRESS == OFS_CTRL_A);
  wire wr_b = acc & (ADDRESS == OFS_CTRL_B);
  wire wr_cnt = acc & (ADDRESS == OFS_COUNT);
  wire wr_rld = acc & (ADDRESS == OFS_RELOAD);
  wire wr_clr = acc & (ADDRESS == OFS_CLEAR);
  wire wr_ien = acc & (ADDRESS == OFS_IRQ_EN);
  wire [DATA_W-1:0] wd = WRITEDATA & wmask;
  wire [DATA_W-1:0] rd_mux =
    (ADDRESS == OFS_CTRL_A) ? {24'h000000, ctrl_a} :
    (ADDRESS == OFS_CTRL_B) ? {22'h0, ctrl_b} :
    (ADDRESS == OFS_COUNT) ? {16'h0000, count} :
    (ADDRESS == OFS_CAPTURE) ? {16'h0000, capture} :
    (ADDRESS == OFS_RELOAD) ? {16'h0000, reload} :
    (ADDRESS == OFS_STATUS) ? {29'h0, status} :
    (ADDRESS == OFS_IRQ_EN) ? {29'h0, irq_en} : 32'h00000000;

  // control fields
  wire gate_en = ctrl_a[GATE_EN_BIT];
  wire one_shot = ctrl_a[ONE_SHOT_BIT];
  wire cpr_en = ctrl_a[CPR_EN_BIT];
  wire run_high = ctrl_a[RUN_HIGH_BIT];
  wire run_low = ctrl_a[RUN_LOW_BIT];
  wire pol = ctrl_a[POL_BIT];
  wire out_en0 = ctrl_a[OUT_EN0_BIT];
  wire split = ctrl_b[SPLIT_BIT];
  wire cnt_sel = ctrl_b[CNT_SEL_BIT];
  wire [1:0] edge_sel = ctrl_b[EDGE_LSB+1:EDGE_LSB];
  wire out_en1 = ctrl_b[OUT_EN1_BIT];
  wire cap_mode = ctrl_b[CAP_MODE_BIT];
  wire [1:0] route = {out_en1, out_en0};
  wire both = (edge_sel == EDGE_BOTH);

  // gating: input pin, timer mode, not both-edge capture
  wire gate_used = gate_en & ~out_en0 & ~cnt_sel & ~both;
  wire gate_ok = ~gate_used | (pin_lvl == pol);
  wire gate_open = gate_used & (pol ? pin_rise : pin_fall);

  // capture edges; shot edge from polarity when both are picked
  wire cap_on = cap_mode & ~out_en0 & ~cnt_sel;
  wire cap_edge = cap_on & ((edge_sel[0] & pin_rise) |
    (edge_sel[1] & pin_fall));
  wire ss_edge = both ? (cap_on & (pol ? pin_fall : pin_rise))
    : cap_edge;
  wire ss_arm = wr_a & wd[ONE_SHOT_BIT] & cap_mode & ss == SS_IDLE;
  wire ss_start = (ss == SS_ARMED) & (ss_edge | gate_open);
  wire ss_end = (ss == SS_RUN) & ss_edge;
  // the starting edge neither captures nor flags
  wire cap_take = cap_edge & (ss != SS_ARMED);
  wire skip_rld = both & gate_en & (pol ? pin_rise : pin_fall);
  wire do_reload = cap_take & cpr_en & ~skip_rld;

  // run control: armed halts the high count, shot run overrides run_high
  wire run_h = (ss == SS_RUN) | (ss == SS_IDLE & run_high);
  wire tick = cnt_sel ? pin_rise : 1'b1;
  wire inc_h = run_h & gate_ok & tick;
  wire inc_l = split & run_low & tick;
  wire hi_top = split ? (count[15:8] == 8'hFF) : (count == 16'hFFFF);
  wire ovf_h = inc_h & hi_top;
  wire ovf_l = inc_l & (count[7:0] == 8'hFF);

  logic [COUNT_W-1:0] next_count;
  logic [CTRL_A_W-1:0] next_ctrl_a;
  logic [ST_W-1:0] ev;

  // counter next value; bus write beats capture reload
  always_comb begin
    next_count = count;
    if (split) begin
      if (inc_h) begin
        next_count[15:8] = ovf_h ? reload[15:8] : count[15:8] + 8'h01;
      end
      if (inc_l) begin
        next_count[7:0] = ovf_l ? reload[7:0] : count[7:0] + 8'h01;
      end
    end else if (inc_h) begin
      next_count = ovf_h ? reload : count + 16'h0001;
    end
    if (do_reload) begin
      next_count = reload;
    end
    if (wr_cnt) begin
      next_count = wd[COUNT_W-1:0];
    end
  end

  // one-shot bit falls when its cycle ends, unless rewritten
  always_comb begin
    next_ctrl_a = ctrl_a;
    if (ss_end) begin
      next_ctrl_a[ONE_SHOT_BIT] = 1'b0;
    end
    if (wr_a) begin
      next_ctrl_a = wd[CTRL_A_W-1:0] | (ctrl_a & ~wmask[CTRL_A_W-1:0]);
    end
  end

  assign ev = {ovf_l, ovf_h, cap_take};

  // bus slave: one wait cycle, read data ready as waitrequest drops
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      WAITREQUEST <= 1'b1;
      READDATA <= 32'h00000000;
    end else begin
      WAITREQUEST <= ~(req & WAITREQUEST);
      if (READ & WAITREQUEST) begin
        READDATA <= rd_mux;
      end
    end
  end

  // control and data registers
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_a <= CTRL_A_RST;
      ctrl_b <= CTRL_B_RST;
      reload <= COUNT_RST;
      count <= COUNT_RST;
      irq_en <= 3'h0;
    end else begin
      ctrl_a <= next_ctrl_a;
      count <= next_count;
      if (wr_b) begin
        ctrl_b <= wd[CTRL_B_W-1:0] | (ctrl_b & ~wmask[CTRL_B_W-1:0]);
      end
      if (wr_rld) begin
        reload <= wd[COUNT_W-1:0] | (reload & ~wmask[COUNT_W-1:0]);
      end
      if (wr_ien) begin
        irq_en <= wd[ST_W-1:0];
      end
    end
  end

  // capture and single-shot sequencer
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      capture <= COUNT_RST;
      ss <= SS_IDLE;
    end else begin
      if (cap_take) begin
        capture <= count;
      end
      unique case (ss)
        SS_IDLE: ss <= ss_arm ? SS_ARMED : SS_IDLE;
        SS_ARMED: ss <= ss_start ? SS_RUN : SS_ARMED;
        SS_RUN: ss <= ss_end ? SS_IDLE : SS_RUN;
        default: ss <= SS_IDLE;
      endcase
    end
  end

  // sticky status: a new event wins over a same-cycle clear
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      status <= 3'h0;
      IRQ <= 1'b0;
    end else begin
      status <= (status & ~(wr_clr ? wd[ST_W-1:0] : 3'h0)) | ev;
      IRQ <= |(status & irq_en);
    end
  end

  // pwm levels; polarity lands on pwm_h only on an out_en0 rise, pwm_l loads 0 on an out_en1 rise
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      out_en0_q <= 1'b0;
      out_en1_q <= 1'b0;
      pwm_h <= 1'b0;
      pwm_l <= 1'b0;
    end else begin
      out_en0_q <= out_en0;
      out_en1_q <= out_en1;
      if (out_en0 & ~out_en0_q) begin
        pwm_h <= pol;
      end else if (ovf_h) begin
        pwm_h <= ~pwm_h;
      end
      if (out_en1 & ~out_en1_q) begin
        pwm_l <= 1'b0;
      end else if (ovf_l) begin
        pwm_l <= ~pwm_l;
      end
    end
  end

  // pin routing; port latch data otherwise, driven when dir is set
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      PIN_A_O <= 1'b0;
      PIN_A_OE <= 1'b0;
      PIN_B_O <= 1'b0;
      PIN_B_OE <= 1'b0;
    end else begin
      PIN_A_O <= route[0] ? pwm_h : ctrl_b[LATCH_A_BIT];
      PIN_A_OE <= route[0] | ctrl_b[DIR_A_BIT];
      PIN_B_O <= route[1] ? (split ? pwm_l : pwm_h)
        : ctrl_b[LATCH_B_BIT];
      PIN_B_OE <= route[1] | ctrl_b[DIR_B_BIT];
    end
  end

  a_stop_hold: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (ss == SS_IDLE && !run_high && !split && !wr_cnt && !do_reload)
    |=> count == $past(count))
    else $error("count moved while stopped");
  a_armed_halt: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (ss == SS_ARMED && !wr_cnt && !do_reload) |=> count == $past(count))
    else $error("count moved while armed");
  a_shot_start: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (ss == SS_ARMED && ss_edge) |=> ss == SS_RUN)
    else $error("shot did not start on edge");
  a_shot_end: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (ss == SS_RUN && ss_edge) |=> ss == SS_IDLE && !ctrl_a[ONE_SHOT_BIT]
      || $past(wr_a))
    else $error("shot did not end on edge");
  a_start_noflag: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (ss == SS_ARMED && !status[ST_CAPTURE]) |=> !status[ST_CAPTURE])
    else $error("flag set on shot start edge");
  a_skip_reload: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (both && gate_en && cap_take && (pol ? pin_rise : pin_fall))
    |-> !do_reload)
    else $error("reload on skipped edge");
  a_low_ignored: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (!split && !run_high && ss == SS_IDLE && !wr_cnt && !do_reload)
    ##1 (!split && !run_high && ss == SS_IDLE && !wr_cnt && !do_reload)
    |=> count == $past(count, 2))
    else $error("low run acted outside split mode");
  a_pol_launch: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (out_en0 && !out_en0_q) |=> pwm_h == $past(pol) ##1 PIN_A_O == pol
      || !out_en0 || $past(ovf_h))
    else $error("polarity not applied on enable");
  a_route_b: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (route == 2'h3 && split) |=> PIN_B_O == $past(pwm_l) && PIN_B_OE)
    else $error("pin b not carrying low pwm");
endmodule : tmr2_ctrl

// ---- inc/tmr2_pkg.sv ----
// Purpose: shared constants for the timer 2 control, capture and pwm block
// Assumes: 32-bit avalon-mm slave, byte addresses, one word per register
// Notes: all offsets and field positions live here and nowhere else
package tmr2_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int COUNT_W = 16;
  localparam int HALF_W = 8;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int CTRL_A_W = 8;
  localparam int CTRL_B_W = 10;
  localparam int ST_W = 3;
  // register byte offsets
  localparam logic [4:0] OFS_CTRL_A = 5'h00;
  localparam logic [4:0] OFS_CTRL_B = 5'h04;
  localparam logic [4:0] OFS_COUNT = 5'h08;
  localparam logic [4:0] OFS_CAPTURE = 5'h0C;
  localparam logic [4:0] OFS_RELOAD = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  localparam logic [4:0] OFS_CLEAR = 5'h18;
  localparam logic [4:0] OFS_IRQ_EN = 5'h1C;
  // timer_ctrl_a fields
  localparam int GATE_EN_BIT = 0;
  localparam int ONE_SHOT_BIT = 1;
  localparam int CPR_EN_BIT = 2;
  localparam int RUN_HIGH_BIT = 3;
  localparam int RUN_LOW_BIT = 4;
  localparam int POL_BIT = 5;
  localparam int OUT_EN0_BIT = 6;
  // timer_ctrl_b fields
  localparam int SPLIT_BIT = 0;
  localparam int CNT_SEL_BIT = 1;
  localparam int EDGE_LSB = 2;
  localparam int OUT_EN1_BIT = 4;
  localparam int CAP_MODE_BIT = 5;
  localparam int LATCH_A_BIT = 6;
  localparam int LATCH_B_BIT = 7;
  localparam int DIR_A_BIT = 8;
  localparam int DIR_B_BIT = 9;
  // status fields
  localparam int ST_CAPTURE = 0;
  localparam int ST_OVF_HIGH = 1;
  localparam int ST_OVF_LOW = 2;
  // reset values
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [9:0] CTRL_B_RST = 10'h000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  // capture edge select codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // single-shot sequencer, gray along idle-armed-run
  typedef enum logic [1:0] {
    SS_IDLE = 2'b00,
    SS_ARMED = 2'b01,
    SS_RUN = 2'b11
  } tmr2_ss_t;
endpackage : tmr2_pkg

// ---- src/tmr2_pin_sync.sv ----
// Purpose: three-stage pin synchroniser with qualified level and edges
// Assumes: pin is asynchronous to clk
// Notes: a change counts once stages two and three agree
`timescale 1ns/1ns
module tmr2_pin_sync (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1;
  logic s2;
  logic s3;
  logic next_level;

  // s1 is only ever read by s2
  assign next_level = (s2 == s3) ? s3 : level;

  // chain and qualified edges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
      rise <= next_level & ~level;
      fall <= ~next_level & level;
    end
  end
endmodule : tmr2_pin_sync

// ---- verification/tmr2_pin_src.sv ----
// Purpose: external signal source model on the primary timer pin
// Assumes: bench sets the level it wants to present on the pin
// Notes: no pull resistor; the driving device wins while it drives
`timescale 1ns/1ns
module tmr2_pin_src (
  input wire logic oe_dut,
  input wire logic o_dut,
  input wire logic drive_lvl,
  output logic pin
);
  // wire level from both parties, fed back into the timer input
  assign pin = oe_dut ? o_dut : drive_lvl;
endmodule : tmr2_pin_src

// ---- verification/tb_timer2_control_capture_pwm.sv ----
// Purpose: self-checking bench for the timer 2 control block
// Assumes: one wait state per bus access, pin sync of 3-4 cycles
// Notes: byte lanes tied all-on; register lanes above 15 read 0
`timescale 1ns/1ns
module tb_timer2_control_capture_pwm;
  import tmr2_pkg::*;
  typedef struct {logic wr; logic [4:0] a; logic [31:0] d;} tmr2_row_t;
  logic CLOCK = 1'b0;
  logic ARST_N = 1'b0;
  logic [4:0] ADDRESS = 5'h00;
  logic READ = 1'b0;
  logic WRITE = 1'b0;
  logic [31:0] WRITEDATA = 32'h0;
  logic [31:0] READDATA;
  logic WAITREQUEST, IRQ, PIN_A_I, PIN_A_O, PIN_A_OE, PIN_B_O, PIN_B_OE;
  logic pin_lvl = 1'b0;
  logic [31:0] q, q2;
  int error_cnt = 0;
  int n_compared = 0;
  tmr2_row_t rows [13];
  // 20 MHz system clock
  always #(CLK_PERIOD_NS/2) CLOCK = ~CLOCK;
  tmr2_ctrl #(.COUNT_W(16)) DUT (.CLOCK(CLOCK), .ARST_N(ARST_N),
    .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
    .BYTEENABLE(4'hF), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
    .IRQ(IRQ), .PIN_A_I(PIN_A_I), .PIN_A_O(PIN_A_O), .PIN_A_OE(PIN_A_OE),
    .PIN_B_O(PIN_B_O), .PIN_B_OE(PIN_B_OE));
  tmr2_pin_src SRC (.oe_dut(PIN_A_OE), .o_dut(PIN_A_O),
    .drive_lvl(pin_lvl), .pin(PIN_A_I));
  task summarize;
    $display("errors %0d compares %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one avalon access; request held until waitrequest seen low
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLOCK);
    READ <= !wr;
    WRITE <= wr;
    ADDRESS <= a;
    WRITEDATA <= d;
    do begin
      @(posedge CLOCK);
      n++;
    end while (WAITREQUEST !== 1'b0 && n < 20);
    q = READDATA;
    READ <= 1'b0;
    WRITE <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1);
  endtask : bus
  task cyc(input int n);
    repeat (n) @(posedge CLOCK);
  endtask : cyc
  task rchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rchk
  // watchdog far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge CLOCK);
    error_cnt++;
    summarize();
  end
  // main sequence
  initial begin
    rows = '{'{1, OFS_CTRL_A, 32'h54}, '{0, OFS_CTRL_A, 32'h54},
      '{1, OFS_CTRL_A, 32'h00}, '{1, OFS_CTRL_B, 32'h3DF},
      '{0, OFS_CTRL_B, 32'h3DF}, '{1, OFS_CTRL_B, 32'h0},
      '{1, OFS_COUNT, 32'hBEEF}, '{0, OFS_COUNT, 32'hBEEF},
      '{1, OFS_CAPTURE, 32'hFFFF}, '{0, OFS_CAPTURE, 32'h0},
      '{0, OFS_CLEAR, 32'h0}, '{0, 5'h03, 32'h0}, '{1, OFS_RELOAD, 32'hFFF0}};
    cyc(8);
    ARST_N <= 1'b1;
    chk({WAITREQUEST, IRQ, PIN_A_OE, PIN_B_OE}, 32'h8);
    rchk(OFS_CTRL_A, 32'h0);
    rchk(OFS_STATUS, 32'h0);
    // register table rows; reads carry their expected value
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk(q, rows[i].d);
    end
    // run, stop and split run control
    bus(1, OFS_COUNT, 32'h0);
    bus(1, OFS_CTRL_A, 32'h08);
    cyc(5);
    rchk(OFS_CTRL_A, 32'h08);
    bus(1, OFS_CTRL_A, 32'h00);
    bus(0, OFS_COUNT, 32'h0);
    chk({31'h0, q != 32'h0}, 32'h1);
    q2 = q;
    cyc(6);
    rchk(OFS_COUNT, q2);
    bus(1, OFS_CTRL_A, 32'h10);
    cyc(6);
    rchk(OFS_COUNT, q2);
    bus(1, OFS_CTRL_A, 32'h00);
    bus(1, OFS_CTRL_B, 32'h1);
    bus(1, OFS_COUNT, 32'h1200);
    bus(1, OFS_CTRL_A, 32'h10);
    cyc(6);
    bus(1, OFS_CTRL_A, 32'h00);
    bus(0, OFS_COUNT, 32'h0);
    chk({q[15:8], 23'h0, q[7:0] != 8'h0}, 32'h12000001);
    // overflow flag, mask, enable and clear
    bus(1, OFS_CTRL_B, 32'h0);
    bus(1, OFS_COUNT, 32'hFFF0);
    bus(1, OFS_CTRL_A, 32'h08);
    cyc(30);
    bus(1, OFS_CTRL_A, 32'h00);
    rchk(OFS_STATUS, 32'h2);
    chk({31'h0, IRQ}, 32'h0);
    bus(1, OFS_IRQ_EN, 32'h2);
    cyc(3);
    chk({31'h0, IRQ}, 32'h1);
    bus(1, OFS_CLEAR, 32'h2);
    cyc(3);
    chk({31'h0, IRQ}, 32'h0);
    rchk(OFS_STATUS, 32'h0);
    // pin routing for every code in both modes
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 4; c++) begin
        bus(1, OFS_CTRL_B, {27'h0, c[1], 3'h0, m[0]});
        bus(1, OFS_CTRL_A, {25'h0, c[0], 6'h0});
        cyc(3);
        chk({PIN_A_OE, PIN_B_OE}, {30'h0, c[0], c[1]});
      end
    end
    bus(1, OFS_CTRL_A, 32'h00);
    bus(1, OFS_CTRL_B, 32'h3C0);
    cyc(3);
    chk({PIN_A_OE, PIN_A_O, PIN_B_OE, PIN_B_O}, 32'hF);
    // polarity reaches the pin only on an enable rise
    bus(1, OFS_CTRL_B, 32'h0);
    bus(1, OFS_CTRL_A, 32'h20);
    bus(1, OFS_CTRL_A, 32'h60);
    cyc(3);
    chk({31'h0, PIN_A_O}, 32'h1);
    bus(1, OFS_CTRL_A, 32'h40);
    cyc(3);
    chk({31'h0, PIN_A_O}, 32'h1);
    bus(1, OFS_CTRL_A, 32'h00);
    bus(1, OFS_CTRL_A, 32'h40);
    cyc(3);
    chk({31'h0, PIN_A_O}, 32'h0);
    // single-shot on both edges, rising edge starts and ends
    bus(1, OFS_CTRL_A, 32'h00);
    bus(1, OFS_CTRL_B, 32'h2C);
    bus(1, OFS_COUNT, 32'h0);
    bus(1, OFS_CTRL_A, 32'h02);
    cyc(10);
    rchk(OFS_COUNT, 32'h0);
    pin_lvl <= 1'b1;
    cyc(8);
    rchk(OFS_STATUS, 32'h0);
    pin_lvl <= 1'b0;
    cyc(8);
    rchk(OFS_CTRL_A, 32'h02);
    bus(1, OFS_CLEAR, 32'h7);
    rchk(OFS_STATUS, 32'h0);
    pin_lvl <= 1'b1;
    cyc(8);
    rchk(OFS_STATUS, 32'h1);
    bus(0, OFS_COUNT, 32'h0);
    chk({31'h0, q != 32'h0}, 32'h1);
    q2 = q;
    cyc(6);
    rchk(OFS_COUNT, q2);
    // capture plus reload on a rising edge, timer stopped
    pin_lvl <= 1'b0;
    cyc(8);
    bus(1, OFS_CTRL_B, 32'h24);
    bus(1, OFS_COUNT, 32'h5);
    bus(1, OFS_CTRL_A, 32'h04);
    pin_lvl <= 1'b1;
    cyc(8);
    rchk(OFS_COUNT, 32'hFFF0);
    rchk(OFS_CAPTURE, 32'h5);
    // reset in mid-run
    @(posedge CLOCK);
    ARST_N <= 1'b0;
    cyc(2);
    chk({WAITREQUEST, IRQ, PIN_A_OE, PIN_B_OE}, 32'h8);
    ARST_N <= 1'b1;
    rchk(OFS_CTRL_B, 32'h0);
    summarize();
  end
endmodule : tb_timer2_control_capture_pwm
